/* hdl/wdtc_pkg.sv */
// constants for the watchdog block: register map, fields, resets, timing
// assumes a 200 MHz core clock and an AXI4-Lite master with 32-bit data
// Function
// - counter runs from a 1 MHz oscillator
// - restart instruction clears the counter
// - disable or chip reset clears the counter
// - expiry while enabled raises a chip reset
// - fuse picks level one off, level two on
// - control bits 7 to 5 read zero
// - change enable self-clears after four cycles
// - enable bit one enables, zero disables
// - disable accepted only while change enable set
// - level two never disables the watchdog
// - select doubles time-out from 16K cycles
// - level one enables on plain write
// - level two enable always reads one
// - level two second write changes select only
// - select changes only inside open window
// - time-out reset pulse lasts one cycle
// - watchdog reset sets flag, zero write clears
package wdtc_pkg;

	// bus geometry
	localparam int          WDTC_ADDR_W          = 4;
	localparam int          WDTC_DATA_W          = 32;
	localparam logic [3:0]  WDTC_CTRL_OFS        = 4'h0;
	localparam logic [3:0]  WDTC_STAT_OFS        = 4'h4;
	localparam logic [1:0]  WDTC_RESP_OKAY       = 2'h0;
	localparam logic [1:0]  WDTC_RESP_SLVERR     = 2'h2;

	// control register fields
	localparam int          WDTC_CE_BIT          = 4;
	localparam int          WDTC_EN_BIT          = 3;
	localparam int          WDTC_SEL_LSB         = 0;
	localparam int          WDTC_SEL_W           = 3;
	localparam logic [2:0]  WDTC_SEL_RST         = 3'h0;

	// status register fields
	localparam int          WDTC_FLAG_BIT        = 3;

	// timing
	localparam int          WDTC_CLK_PERIOD_PS   = 5000;
	localparam int          WDTC_OSC_PERIOD_PS   = 1000000;
	localparam int          WDTC_TICK_CYC        = WDTC_OSC_PERIOD_PS / WDTC_CLK_PERIOD_PS;
	localparam int          WDTC_TICK_W          = 8;
	localparam logic [2:0]  WDTC_CE_WINDOW_CYC   = 3'h4;
	localparam int          WDTC_TIMEOUT_BASE    = 16384;
	localparam int          WDTC_CNT_W           = 22;

	// register selected by an address
	typedef enum logic [1:0] {
		WDTC_REG_CTRL,
		WDTC_REG_STAT,
		WDTC_REG_NONE
	} wdtc_reg_e;

endpackage

/* hdl/wdtc_osc_tick.sv */
// stand-in for the watchdog oscillator: one-cycle tick at 1 MHz
// assumes the 200 MHz core clock and its clock enable
`timescale 1ns/10ps
module wdtc_osc_tick
	import wdtc_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic clk_en,
	output logic      osc_tick
);

	typedef struct packed {
		logic [WDTC_TICK_W-1:0] div;
		logic                   tick;
	} wdtc_tick_s;

	wdtc_tick_s st_r;
	wdtc_tick_s st_nxt;

	// divide core clock down to the oscillator rate
	always_comb begin
		st_nxt      = st_r;
		st_nxt.tick = 1'b0;
		if (st_r.div == WDTC_TICK_W'(WDTC_TICK_CYC - 1)) begin
			st_nxt.div  = '0;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.div = st_r.div + 8'h01;
		end
		if (!aresetn) begin
			st_nxt = '0;
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn || clk_en) begin
			st_r <= st_nxt;
		end
	end

	assign osc_tick = st_r.tick;

endmodule

/* hdl/wdtc_top.sv */
// watchdog timer with timed configuration, behind an AXI4-Lite slave
// assumes synchronous inputs, one 200 MHz clock, static fuse level
`timescale 1ns/10ps
module wdtc_top
	import wdtc_pkg::*;
#(
	parameter int unsigned TIMEOUT_BASE = WDTC_TIMEOUT_BASE
)
(
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire logic                     clk_en,
	input  wire logic                     por_n,
	input  wire logic                     safety_level_fuse,
	input  wire logic                     restart_pulse,
	output logic                          chip_reset_pulse,
	output logic                          dog_enable,
	input  wire logic [WDTC_ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [WDTC_DATA_W-1:0]   s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [WDTC_ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [WDTC_DATA_W-1:0]        s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready
);

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic                   en;
		logic [WDTC_SEL_W-1:0]  sel;
		logic                   ce;
		logic [2:0]             ce_cnt;
		logic [WDTC_CNT_W-1:0]  cnt;
		logic                   flag;
		logic                   rst_pulse;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   rvalid;
		logic [WDTC_DATA_W-1:0] rdata;
		logic [1:0]             rresp;
	} wdtc_core_s;

	wdtc_core_s             st_r;
	wdtc_core_s             st_nxt;
	logic                   osc_tick;
	logic                   wr_fire;
	logic                   rd_fire;
	logic [WDTC_CNT_W-1:0]  limit;
	wdtc_reg_e              wr_reg;
	wdtc_reg_e              rd_reg;

	// address decode shared by both channels
	function automatic wdtc_reg_e reg_decode(input logic [WDTC_ADDR_W-1:0] addr);
		wdtc_reg_e r;
		r = WDTC_REG_NONE;
		if (addr == WDTC_CTRL_OFS) begin
			r = WDTC_REG_CTRL;
		end else if (addr == WDTC_STAT_OFS) begin
			r = WDTC_REG_STAT;
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// oscillator tick

	// 1 MHz tick for the watchdog counter
	wdtc_osc_tick u_tick (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.clk_en   (clk_en),
		.osc_tick (osc_tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// handshakes

	// write taken only with address and data together
	assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !st_r.bvalid;
	assign rd_fire       = s_axi_arvalid && !st_r.rvalid;
	assign s_axi_awready = wr_fire;
	assign s_axi_wready  = wr_fire;
	assign s_axi_arready = !st_r.rvalid;
	assign wr_reg        = reg_decode(s_axi_awaddr);
	assign rd_reg        = reg_decode(s_axi_araddr);

	// time-out length in oscillator cycles
	assign limit = WDTC_CNT_W'(TIMEOUT_BASE) << st_r.sel;

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_nxt           = st_r;
		st_nxt.rst_pulse = 1'b0;

		// answers leave when taken
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end

		// change window counts down and closes itself
		if (st_r.ce) begin
			st_nxt.ce_cnt = st_r.ce_cnt - 3'h1;
			if (st_r.ce_cnt == 3'h1) begin
				st_nxt.ce = 1'b0;
			end
		end

		// register writes
		if (wr_fire) begin
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp  = WDTC_RESP_OKAY;
			if (wr_reg == WDTC_REG_CTRL) begin
				if (s_axi_wstrb[0]) begin
					if (st_r.ce) begin
						// window open: enable and select take the written values
						st_nxt.en  = s_axi_wdata[WDTC_EN_BIT];
						st_nxt.sel = s_axi_wdata[WDTC_SEL_LSB +: WDTC_SEL_W];
						st_nxt.ce  = 1'b0;
					end else if (s_axi_wdata[WDTC_EN_BIT]) begin
						// window closed: only a set of enable lands
						st_nxt.en = 1'b1;
					end
					if (s_axi_wdata[WDTC_CE_BIT]) begin
						st_nxt.ce     = 1'b1;
						st_nxt.ce_cnt = WDTC_CE_WINDOW_CYC;
					end
				end
			end else if (wr_reg == WDTC_REG_STAT) begin
				if (s_axi_wstrb[0] && !s_axi_wdata[WDTC_FLAG_BIT]) begin
					st_nxt.flag = 1'b0;
				end
			end else begin
				st_nxt.bresp = WDTC_RESP_SLVERR;
			end
		end

		// level two keeps the dog running whatever was written
		if (safety_level_fuse) begin
			st_nxt.en = 1'b1;
		end

		// watchdog counter
		if (restart_pulse || !st_nxt.en || st_r.rst_pulse) begin
			st_nxt.cnt = '0;
		end else if (osc_tick && st_r.en) begin
			if (st_r.cnt == limit - 22'h000001) begin
				st_nxt.cnt       = '0;
				st_nxt.rst_pulse = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt + 22'h000001;
			end
		end

		// set of the reset flag wins over a clear
		if (st_nxt.rst_pulse) begin
			st_nxt.flag = 1'b1;
		end

		// register reads
		if (rd_fire) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp  = WDTC_RESP_OKAY;
			st_nxt.rdata  = '0;
			if (rd_reg == WDTC_REG_CTRL) begin
				st_nxt.rdata[WDTC_CE_BIT]                     = st_r.ce;
				st_nxt.rdata[WDTC_EN_BIT]                     = st_r.en;
				st_nxt.rdata[WDTC_SEL_LSB +: WDTC_SEL_W]      = st_r.sel;
			end else if (rd_reg == WDTC_REG_STAT) begin
				st_nxt.rdata[WDTC_FLAG_BIT] = st_r.flag;
			end else begin
				st_nxt.rresp = WDTC_RESP_SLVERR;
			end
		end

		// chip reset: fuse picks the initial enable, flag survives
		if (!aresetn) begin
			st_nxt      = '0;
			st_nxt.sel  = WDTC_SEL_RST;
			st_nxt.en   = safety_level_fuse;
			st_nxt.flag = st_r.flag;
		end
		if (!por_n) begin
			st_nxt.flag = 1'b0;
		end
	end

	// state register, frozen while the clock enable is low unless aresetn or por_n is low
	always_ff @(posedge aclk) begin
		if (!aresetn || !por_n || clk_en) begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign chip_reset_pulse = st_r.rst_pulse;
	assign dog_enable       = st_r.en;
	assign s_axi_bvalid     = st_r.bvalid;
	assign s_axi_bresp      = st_r.bresp;
	assign s_axi_rvalid     = st_r.rvalid;
	assign s_axi_rdata      = st_r.rdata;
	assign s_axi_rresp      = st_r.rresp;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn || !por_n);

	// a control write in the cycle it is taken
	logic ctrl_wr;
	assign ctrl_wr = wr_fire && clk_en && (wr_reg == WDTC_REG_CTRL) && s_axi_wstrb[0];

	// counter sits at its final value on a live tick
	sequence s_expiry;
		clk_en && osc_tick && st_r.en && !restart_pulse && !st_r.rst_pulse
			&& (st_r.cnt == limit - 22'h000001);
	endsequence

	// opening write of the change window
	sequence s_open;
		ctrl_wr && s_axi_wdata[WDTC_CE_BIT];
	endsequence

	// expiry gives a reset pulse on the next edge
	a_expiry_resets: assert property (
		s_expiry |=> chip_reset_pulse
	) else $error("time-out did not raise the chip reset");

	// pulse is a single cycle and the flag follows it
	a_pulse_single: assert property (
		chip_reset_pulse && clk_en |=> !chip_reset_pulse
	) else $error("chip reset pulse longer than one cycle");

	a_flag_on_reset: assert property (
		chip_reset_pulse |-> st_r.flag
	) else $error("reset flag not set by watchdog reset");

	// window stays open four cycles then closes unless rewritten
	a_window_four: assert property (
		s_open ##1 (clk_en && !wr_fire) [*4] |=> !st_r.ce
	) else $error("change enable not cleared after four cycles");

	a_window_open: assert property (
		s_open |=> st_r.ce && (st_r.ce_cnt == 3'h4)
	) else $error("change enable not set by write");

	// closed window keeps enable and select
	a_closed_keeps: assert property (
		ctrl_wr && !st_r.ce && st_r.en |=> st_r.en && $stable(st_r.sel)
	) else $error("closed window write changed the configuration");

	// select only moves inside a window
	a_sel_locked: assert property (
		!(ctrl_wr && st_r.ce) && clk_en |=> $stable(st_r.sel)
	) else $error("time-out select changed without open window");

	// level two keeps running and reads one
	a_level2_on: assert property (
		safety_level_fuse && $past(safety_level_fuse) |-> st_r.en
	) else $error("level two watchdog found disabled");

	// disabled or restarted dog holds zero
	a_disabled_zero: assert property (
		!st_r.en |-> st_r.cnt == '0
	) else $error("counter not clear while disabled");

	a_restart_zero: assert property (
		restart_pulse && clk_en |=> st_r.cnt == '0
	) else $error("restart did not clear the counter");

	// level one plain set enables
	a_plain_enable: assert property (
		ctrl_wr && s_axi_wdata[WDTC_EN_BIT] |=> st_r.en
	) else $error("write of one did not enable the watchdog");

	// reserved control bits read zero
	a_reserved_zero: assert property (
		s_axi_rvalid |-> s_axi_rdata[7:5] == 3'h0
	) else $error("reserved bits read non-zero");

endmodule

/* bench/wdtc_top_tb.sv */
// self-checking bench for the watchdog block behind its AXI4-Lite slave
// assumes the design package and wdtc_top compiled before this file
`timescale 1ns/10ps
module wdtc_top_tb;
	import wdtc_pkg::*;

	localparam int TB_BASE = 4;
	localparam int TICK    = 200;

	typedef struct {
		logic [3:0]  a;
		logic [31:0] d;
		logic [1:0]  eb;
		logic [31:0] er;
		logic [1:0]  err;
	} wdtc_tb_row_s;

	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        por_n = 1'b0;
	logic        fuse = 1'b0;
	logic        restart_pulse = 1'b0;
	logic        chip_reset_pulse;
	logic        dog_enable;
	logic [3:0]  awaddr = 4'h0;
	logic        awvalid = 1'b0;
	logic        awready;
	logic [31:0] wdata = 32'h0;
	logic        wvalid = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic [3:0]  araddr = 4'h0;
	logic        arvalid = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	int          err_total = 0;
	int          cmp_count = 0;
	logic [31:0] v;
	logic [1:0]  r;
	int          n;
	wdtc_tb_row_s rows [4];

	// core clock, 5 ns period
	always #2.5 aclk = ~aclk;

	wdtc_top #(.TIMEOUT_BASE(TB_BASE)) i_wdtc_top (
		.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .por_n(por_n),
		.safety_level_fuse(fuse), .restart_pulse(restart_pulse),
		.chip_reset_pulse(chip_reset_pulse), .dog_enable(dog_enable),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(1'b1)
	);

	////////////////////////////////////////////////////////////////////////
	// checks and verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("mismatches %0d comparisons %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// bounded wait on a settled level, seen at the falling edge
	task automatic await(ref logic s);
		int k;
		k = 0;
		do begin
			@(negedge aclk);
			k++;
		end while (s !== 1'b1 && k < 100);
		if (k >= 100) chk(32'h0, 32'h1, "handshake hang");
	endtask

	////////////////////////////////////////////////////////////////////////
	// bus cycles, entered and left just after a rising edge
	task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rs);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		await(awready);
		@(posedge aclk);
		awvalid <= 1'b0;
		wvalid  <= 1'b0;
		await(bvalid);
		rs = bresp;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rs);
		araddr  <= a;
		arvalid <= 1'b1;
		await(arready);
		@(posedge aclk);
		arvalid <= 1'b0;
		await(rvalid);
		d  = rdata;
		rs = rresp;
		@(posedge aclk);
	endtask

	task automatic rdchk(input logic [3:0] a, input logic [31:0] e, input string m);
		rd(a, v, r);
		chk(v, e, m);
	endtask

	// open the window, then load enable and select
	task automatic timed(input logic [7:0] d);
		wr(WDTC_CTRL_OFS, 32'h18, r);
		wr(WDTC_CTRL_OFS, {24'h0, d}, r);
	endtask

	task automatic reset_all(input logic f);
		aresetn <= 1'b0;
		por_n   <= 1'b0;
		fuse    <= f;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		por_n   <= 1'b1;
		@(posedge aclk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// watchdog span
	initial begin
		#(40000 * 5);
		err_total++;
		give_verdict();
	end

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rows[0] = '{WDTC_CTRL_OFS, 32'he8, WDTC_RESP_OKAY, 32'h08, WDTC_RESP_OKAY};
		rows[1] = '{WDTC_CTRL_OFS, 32'h05, WDTC_RESP_OKAY, 32'h08, WDTC_RESP_OKAY};
		rows[2] = '{4'h8, 32'h0f, WDTC_RESP_SLVERR, 32'h0, WDTC_RESP_SLVERR};
		rows[3] = '{WDTC_STAT_OFS, 32'h00, WDTC_RESP_OKAY, 32'h0, WDTC_RESP_OKAY};
		reset_all(1'b0);
		chk({31'h0, dog_enable}, 32'h0, "level one starts off");
		rdchk(WDTC_CTRL_OFS, 32'h0, "ctrl after reset");
		// ordinary rows: write, then read back
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d, r);
			chk({30'h0, r}, {30'h0, rows[i].eb}, "bresp");
			rd(rows[i].a, v, r);
			chk(v, rows[i].er, "row data");
			chk({30'h0, r}, {30'h0, rows[i].err}, "rresp");
		end
		// back-to-back timed disable with a new select
		timed(8'h03);
		rdchk(WDTC_CTRL_OFS, 32'h03, "timed disable");
		chk({31'h0, dog_enable}, 32'h0, "dog off");
		// window expires, then disable refused
		wr(WDTC_CTRL_OFS, 32'h18, r);
		repeat (6) @(posedge aclk);
		rdchk(WDTC_CTRL_OFS, 32'h0b, "change enable cleared");
		wr(WDTC_CTRL_OFS, 32'h00, r);
		rdchk(WDTC_CTRL_OFS, 32'h0b, "late disable refused");
		// time-out per select code, codes 3 down to 0
		for (int s = 3; s >= 0; s--) begin
			timed(8'h08 | 8'(s));
			rdchk(WDTC_CTRL_OFS, 32'h08 | 32'(s), "select");
			restart_pulse <= 1'b1;
			@(posedge aclk);
			restart_pulse <= 1'b0;
			n = 0;
			do begin
				@(negedge aclk);
				n++;
			end while (chip_reset_pulse !== 1'b1 && n < 7000);
			chk(32'(n >= ((TB_BASE << s) - 1) * TICK), 32'h1, "early");
			chk(32'(n <= (TB_BASE << s) * TICK + 3), 32'h1, "late");
			@(negedge aclk);
			chk({31'h0, chip_reset_pulse}, 32'h0, "pulse width");
			@(posedge aclk);
		end
		rdchk(WDTC_STAT_OFS, 32'h08, "flag set");
		wr(WDTC_STAT_OFS, 32'h0, r);
		rdchk(WDTC_STAT_OFS, 32'h0, "flag cleared");
		// regular restarts keep the chip alive
		n = 0;
		for (int i = 0; i < 2000; i++) begin
			restart_pulse <= (i % 500 == 0);
			@(negedge aclk);
			if (chip_reset_pulse === 1'b1) n++;
			@(posedge aclk);
		end
		chk(32'(n), 32'h0, "restart ignored");
		// level two
		reset_all(1'b1);
		chk({31'h0, dog_enable}, 32'h1, "level two starts on");
		rdchk(WDTC_CTRL_OFS, 32'h08, "level two ctrl");
		timed(8'h02);
		rdchk(WDTC_CTRL_OFS, 32'h0a, "level two select");
		timed(8'h00);
		chk({31'h0, dog_enable}, 32'h1, "never disabled");
		rdchk(WDTC_CTRL_OFS, 32'h08, "enable reads one");
		give_verdict();
	end
endmodule
